// file: hw/adf_pkg.sv
// Shared constants and types of the decimation filter chain
`default_nettype none
package adf_pkg;
   localparam int NCH = 4;
   localparam int DW = 24;
   localparam int CW = 32;
   localparam int EST_FRAC = 16;
   localparam int EW = DW + EST_FRAC;
   localparam int AW = 8;
   // Register byte addresses
   localparam logic [AW-1:0] ADDR_CLOCK = 8'h00;
   localparam logic [AW-1:0] ADDR_HPF = 8'h04;
   localparam logic [AW-1:0] ADDR_CHOFF = 8'h08;
   localparam logic [AW-1:0] ADDR_CTRL = 8'h0c;
   localparam logic [AW-1:0] ADDR_STATUS = 8'h10;
   // Field positions and reset values
   localparam int CTRL_RESYNC = 0;
   localparam int ST_MAIN = 0;
   localparam int ST_SETTLED = 1;
   localparam int ST_OVR = 2;
   localparam int ST_CONV = 4;
   localparam logic [2:0] OSR_RST = 3'h3;
   localparam logic [3:0] HPF_RST = 4'h0;
   localparam logic [2:0] OSR_SPLIT = 3'h4;
   localparam logic [3:0] LG_OSR_MIN = 4'h7;
   localparam logic [3:0] LG_SINC3_MAX = 4'ha;
   localparam logic [1:0] FAST_CONV = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // Settling in master-clock periods, ratio 128 first
   localparam int unsigned SETTLE_TAB [8] = '{856, 1112, 1624, 2648, 4696, 8792, 16984, 33368};
   typedef enum logic [0:0] {PH_FAST = 1'b0, PH_MAIN = 1'b1} adf_phase_t;
   typedef struct packed {
      logic fast;
      logic [NCH-1:0][DW-1:0] chan;
   } adf_sample_t;
endpackage
`default_nettype wire

// file: hw/adf_buf2.sv
// Two-entry stream buffer with valid and ready on both sides
`default_nettype none
module adf_buf2
#(
   parameter int W = 8,
   parameter int DEPTH = 2
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam int NW = $clog2(DEPTH + 1);
   logic [W-1:0] mem_q [DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [NW-1:0] cnt_q;
   logic push;
   logic pop;

   // Honest full and empty from the fill count
   assign in_ready = cnt_q != NW'(DEPTH);
   assign out_valid = cnt_q != '0;
   assign out_data = mem_q[rp_q];
   assign push = ce && in_valid && in_ready;
   assign pop = ce && out_valid && out_ready;

   // Pointers wrap at the depth, which need not be a power of two
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : wp_q + PW'(1);
         if (pop)
            rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : rp_q + PW'(1);
         cnt_q <= cnt_q + NW'(push) - NW'(pop);
      end
   end

   // Storage needs no reset, it is only read when counted valid
   always_ff @(posedge aclk)
   begin
      if (push)
         mem_q[wp_q] <= in_data;
   end
endmodule
`default_nettype wire

// file: hw/adf_sinc3.sv
// Third-order integrator-comb decimator for one channel
`default_nettype none
module adf_sinc3
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic clr,
   input wire logic mod_tick,
   input wire logic mod_bit,
   input wire logic dec_tick,
   input wire logic [4:0] shl,
   output logic [adf_pkg::DW-1:0] out_q
);
   import adf_pkg::*;
   logic [CW-1:0] i1_q;
   logic [CW-1:0] i2_q;
   logic [CW-1:0] i3_q;
   logic [CW-1:0] c1_q;
   logic [CW-1:0] c2_q;
   logic [CW-1:0] c3_q;
   logic [CW-1:0] x;
   logic [CW-1:0] d1;
   logic [CW-1:0] d2;
   logic [CW-1:0] d3;
   logic [CW-1:0] norm;

   // Bit one counts +1, bit zero -1; wrapping sums stay exact
   assign x = mod_bit ? CW'(1) : '1;
   // combs place nulls at multiples of the output rate
   assign d1 = i3_q - c1_q;
   assign d2 = d1 - c2_q;
   assign d3 = d2 - c3_q;
   assign norm = d3 << shl;

   // integrators at modulator rate, combs at decimated rate
   always_ff @(posedge aclk)
   begin
      if (!aresetn || (ce && clr))
      begin
         i1_q <= '0;
         i2_q <= '0;
         i3_q <= '0;
         c1_q <= '0;
         c2_q <= '0;
         c3_q <= '0;
         out_q <= '0;
      end
      else if (ce && mod_tick)
      begin
         i1_q <= i1_q + x;
         i2_q <= i2_q + i1_q;
         i3_q <= i3_q + i2_q;
         if (dec_tick)
         begin
            c1_q <= i3_q;
            c2_q <= d1;
            c3_q <= d2;
            out_q <= norm[CW-1:CW-DW];
         end
      end
   end
endmodule
`default_nettype wire

// file: hw/adf_chain.sv
// Decimation filter chain: fast and sinc paths, DC block, register slave
//
// Notes on behaviour
// - After reset each channel first uses a first-order moving-average path.
// - After two fast conversions switch to sinc3 and stay until reset.
// - Ratios 128 to 1024: sinc3 decimates by the full ratio, output direct.
// - Ratios 2048 and up: sinc3 fixed at 1024, sinc1 does the rest.
// - Sinc3 is the cubed length-N average, unity gain at DC.
// - Nulls at every multiple of output rate except modulator multiples.
// - Results keep flowing while filters settle; nothing suppressed, a status bit flags settling.
// - Settling counts per ratio: 856 up to 33368 master clocks.
// - Nonzero corner select enables the DC block; zero bypasses all channels.
// - A per-channel off bit bypasses that channel's DC block.
// - DC block coefficient is two to the minus (code plus one).
// - DC block steps once per output sample.
// - Modulator runs at half the master clock; ratio sets output rate.
// - A 3-bit field picks ratios 128 to 16384 in powers of two.
// - Fast path and sinc3 path work in parallel on the same bits.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`default_nettype none
module adf_chain
#(
   parameter int unsigned SETTLE_CLK [8] = adf_pkg::SETTLE_TAB
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [adf_pkg::NCH-1:0] mod_bits,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [adf_pkg::AW-1:0] s_awaddr,
   input wire logic s_wvalid,
   output logic s_wready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   output logic s_bvalid,
   input wire logic s_bready,
   output logic [1:0] s_bresp,
   input wire logic s_arvalid,
   output logic s_arready,
   input wire logic [adf_pkg::AW-1:0] s_araddr,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic smp_valid,
   input wire logic smp_ready,
   output adf_pkg::adf_sample_t smp_data,
   output logic sample_ready_n
);
   import adf_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic [2:0] osr_q;
   logic [3:0] corner_q;
   logic [NCH-1:0] choff_q;
   logic ovr_q;
   adf_phase_t phase_q;
   logic [1:0] conv_q;
   logic [15:0] settle_q;
   logic mod_tick_q;
   logic [9:0] cnt3_q;
   logic [3:0] cntm_q;
   logic [13:0] cntf_q;
   logic ev3_q;
   logic evm_q;
   logic evf_q;
   logic lastm_q;
   logic awf_q;
   logic wf_q;
   logic bvalid_q;
   logic rvalid_q;
   logic [AW-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   adf_sample_t pend_q;
   logic pend_v_q;
   logic [3:0] lg_osr;
   logic [3:0] lg3;
   logic [3:0] lgm;
   logic cascade;
   logic [9:0] n3_last;
   logic [3:0] m_last;
   logic [13:0] f_last;
   logic [4:0] shl3;
   logic [4:0] fshl;
   logic end3;
   logic endf;
   logic ev_out;
   logic resync;
   logic settled;
   logic wr_go;
   logic wr_byte;
   logic wr_ok;
   logic rd_ok;
   logic [31:0] rd_word;
   logic [31:0] status_word;
   logic buf_in_ready;
   logic take;
   logic ovr_set;
   logic [NCH-1:0][DW-1:0] word;
   logic [NCH-1:0][DW-1:0] raw_all;

   // ratio split between sinc3 and the trailing sinc1
   assign lg_osr = LG_OSR_MIN + 4'(osr_q);
   assign cascade = osr_q >= OSR_SPLIT;
   assign lg3 = cascade ? LG_SINC3_MAX : lg_osr;
   assign lgm = cascade ? lg_osr - LG_SINC3_MAX : 4'h0;
   assign n3_last = 10'((16'h1 << lg3) - 16'h1);
   assign m_last = 4'((5'h1 << lgm) - 5'h1);
   assign f_last = 14'((16'h1 << lg_osr) - 16'h1);
   assign shl3 = 5'(6'd30 - 6'd3 * 6'(lg3));
   assign fshl = 5'(5'd22 - 5'(lg_osr));
   assign end3 = ce && mod_tick_q && cnt3_q == n3_last;
   assign endf = ce && mod_tick_q && cntf_q == f_last;

   // Register write decode; a new ratio restarts the filters
   assign wr_go = ce && awf_q && wf_q && !bvalid_q;
   assign wr_byte = wr_go && wstrb_q[0];
   assign wr_ok = awaddr_q inside {ADDR_CLOCK, ADDR_HPF, ADDR_CHOFF, ADDR_CTRL, ADDR_STATUS};
   assign resync = wr_byte && ((awaddr_q == ADDR_CLOCK && wdata_q[2:0] != osr_q)
                   || (awaddr_q == ADDR_CTRL && wdata_q[CTRL_RESYNC]));

   // modulator tick every second master clock
   always_ff @(posedge aclk)
   begin
      if (!aresetn || resync)
      begin
         mod_tick_q <= 1'b0;
         cnt3_q <= '0;
         cntm_q <= '0;
         cntf_q <= '0;
      end
      else if (ce && mod_tick_q)
      begin
         mod_tick_q <= 1'b0;
         cnt3_q <= end3 ? '0 : cnt3_q + 10'h1;
         cntf_q <= endf ? '0 : cntf_q + 14'h1;
         if (end3)
            cntm_q <= (cntm_q == m_last) ? '0 : cntm_q + 4'h1;
      end
      else if (ce)
         mod_tick_q <= 1'b1;
   end

   // Conversion events, one cycle after the frame closes; the cascade event comes two cycles after
   always_ff @(posedge aclk)
   begin
      if (!aresetn || resync)
      begin
         ev3_q <= 1'b0;
         evf_q <= 1'b0;
         evm_q <= 1'b0;
         lastm_q <= 1'b0;
      end
      else if (ce)
      begin
         ev3_q <= end3;
         evf_q <= endf;
         evm_q <= ev3_q && lastm_q && cascade;
         if (end3)
            lastm_q <= cntm_q == m_last;
      end
   end

   // two fast conversions, then sinc3 until the next reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         phase_q <= PH_FAST;
         conv_q <= '0;
      end
      else if (ce)
      begin
         unique case (phase_q)
            PH_FAST:
            begin
               if (evf_q)
               begin
                  conv_q <= conv_q + 2'h1;
                  if (conv_q == FAST_CONV - 2'h1)
                     phase_q <= PH_MAIN;
               end
            end
            PH_MAIN: phase_q <= PH_MAIN;
         endcase
      end
   end

   // sinc3 straight out; cascade output; fast path first
   assign ev_out = ce && (phase_q == PH_FAST ? evf_q : cascade ? evm_q : ev3_q);

   generate
      for (genvar c = 0; c < NCH; c++)
      begin : g_ch
         logic [DW-1:0] s3;
         logic [15:0] facc_q;
         logic [15:0] fnext;
         logic signed [27:0] pacc_q;
         logic signed [27:0] pnext;
         logic [DW-1:0] fast_q;
         logic [DW-1:0] post_q;
         logic [DW-1:0] raw;
         logic [DW-1:0] y;
         logic signed [EW-1:0] est_q;
         logic signed [EW-1:0] yx;
         logic signed [EW-1:0] step;
         logic hpf_on;

         // sinc3 runs beside the fast path on the same bits
         adf_sinc3 u_sinc3 (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .clr(resync),
            .mod_tick(mod_tick_q),
            .mod_bit(mod_bits[c]),
            .dec_tick(end3),
            .shl(shl3),
            .out_q(s3)
         );

         // moving average over the full ratio, scaled to sinc3 gain
         assign fnext = facc_q + (mod_bits[c] ? 16'h0001 : 16'hffff);
         // sinc1 sums 2 to 16 sinc3 results and divides by the count
         assign pnext = pacc_q + 28'($signed(s3));

         // all path state cleared on reset and resync
         always_ff @(posedge aclk)
         begin
            if (!aresetn || resync)
            begin
               facc_q <= '0;
               pacc_q <= '0;
               fast_q <= '0;
               post_q <= '0;
            end
            else if (ce)
            begin
               if (mod_tick_q)
                  facc_q <= endf ? '0 : fnext;
               if (endf)
                  fast_q <= {{(DW-16){fnext[15]}}, fnext} << fshl;
               if (ev3_q)
                  pacc_q <= lastm_q ? '0 : pnext;
               if (ev3_q && lastm_q)
                  post_q <= DW'(pnext >>> lgm);
            end
         end

         assign raw = (phase_q == PH_FAST) ? fast_q : cascade ? post_q : s3;
         assign raw_all[c] = raw;
         // global corner select and per-channel off bit
         assign hpf_on = corner_q != 4'h0 && !choff_q[c];
         // error against the running DC estimate
         assign y = raw - est_q[EW-1 -: DW];
         assign yx = {y, {EST_FRAC{1'b0}}};
         // coefficient is a right shift of code plus one
         assign step = yx >>> (5'(corner_q) + 5'h1);
         assign word[c] = hpf_on ? y : raw;

         // estimate moves once per output sample
         always_ff @(posedge aclk)
         begin
            if (!aresetn || resync)
               est_q <= '0;
            else if (ev_out && hpf_on)
               est_q <= est_q + step;
         end
      end
   endgenerate

   // every result is passed on, settled or not; a stall overwrites
   assign take = ce && pend_v_q && buf_in_ready;
   assign ovr_set = ev_out && pend_v_q && !take;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pend_v_q <= 1'b0;
         pend_q <= '0;
      end
      else if (ev_out)
      begin
         pend_v_q <= 1'b1;
         pend_q <= '{fast: phase_q == PH_FAST, chan: word};
      end
      else if (take)
         pend_v_q <= 1'b0;
   end

   adf_buf2 #(.W($bits(adf_sample_t)), .DEPTH(2)) u_buf (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .in_valid(pend_v_q),
      .in_ready(buf_in_ready),
      .in_data(pend_q),
      .out_valid(smp_valid),
      .out_ready(smp_ready),
      .out_data(smp_data)
   );
   assign sample_ready_n = !smp_valid;

   // settling counter restarts on reset and resync
   assign settled = settle_q >= 16'(SETTLE_CLK[osr_q]);
   always_ff @(posedge aclk)
   begin
      if (!aresetn || resync)
         settle_q <= '0;
      else if (ce && !settled)
         settle_q <= settle_q + 16'h1;
   end

   // ratio select and DC block controls
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         osr_q <= OSR_RST;
         corner_q <= HPF_RST;
         choff_q <= '0;
      end
      else if (wr_byte)
      begin
         if (awaddr_q == ADDR_CLOCK)
            osr_q <= wdata_q[2:0];
         if (awaddr_q == ADDR_HPF)
            corner_q <= wdata_q[3:0];
         if (awaddr_q == ADDR_CHOFF)
            choff_q <= wdata_q[NCH-1:0];
      end
   end

   // Overrun flag: a new event beats a write-one clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ovr_q <= 1'b0;
      else if (ovr_set)
         ovr_q <= 1'b1;
      else if (wr_byte && awaddr_q == ADDR_STATUS && wdata_q[ST_OVR])
         ovr_q <= 1'b0;
   end

   // Read selection; unmapped addresses answer a decode error
   always_comb
   begin
      status_word = '0;
      status_word[ST_MAIN] = phase_q == PH_MAIN;
      status_word[ST_SETTLED] = settled;
      status_word[ST_OVR] = ovr_q;
      status_word[ST_CONV +: 2] = conv_q;
   end
   assign rd_ok = s_araddr inside {ADDR_CLOCK, ADDR_HPF, ADDR_CHOFF, ADDR_CTRL, ADDR_STATUS};
   assign rd_word = (s_araddr == ADDR_CLOCK) ? 32'(osr_q) :
                    (s_araddr == ADDR_HPF) ? 32'(corner_q) :
                    (s_araddr == ADDR_CHOFF) ? 32'(choff_q) :
                    (s_araddr == ADDR_STATUS) ? status_word : 32'h0;

   // One write and one read in flight; readies drop while frozen
   assign s_awready = ce && !awf_q && !bvalid_q;
   assign s_wready = ce && !wf_q && !bvalid_q;
   assign s_arready = ce && !rvalid_q;
   assign s_bvalid = bvalid_q;
   assign s_bresp = bresp_q;
   assign s_rvalid = rvalid_q;
   assign s_rdata = rdata_q;
   assign s_rresp = rresp_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awf_q <= 1'b0;
         wf_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         awf_q <= 1'b0;
         wf_q <= 1'b0;
         bvalid_q <= 1'b1;
         bresp_q <= wr_ok ? RESP_OKAY : RESP_DECERR;
      end
      else
      begin
         if (s_awvalid && s_awready)
            awf_q <= 1'b1;
         if (s_wvalid && s_wready)
            wf_q <= 1'b1;
         if (ce && bvalid_q && s_bready)
            bvalid_q <= 1'b0;
      end
   end

   // Address and data latches, taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end
      else
      begin
         if (s_awvalid && s_awready)
            awaddr_q <= s_awaddr;
         if (s_wvalid && s_wready)
         begin
            wdata_q <= s_wdata;
            wstrb_q <= s_wstrb;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end
      else if (s_arvalid && s_arready)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_ok ? RESP_OKAY : RESP_DECERR;
      end
      else if (ce && rvalid_q && s_rready)
         rvalid_q <= 1'b0;
   end

   sequence s_second_fast;
      ce && phase_q == PH_FAST && evf_q && conv_q == 2'h1;
   endsequence

   chk_mod_half_rate: assert property (ce && mod_tick_q ##1 ce |-> !mod_tick_q)
      else $error("modulator tick ran at the full clock rate");
   chk_fast_first: assert property (ev_out && phase_q == PH_FAST |=> pend_v_q && pend_q.fast)
      else $error("early result did not come from the fast path");
   chk_fast_to_main: assert property (s_second_fast |=> phase_q == PH_MAIN)
      else $error("no switch to sinc3 after two fast results");
   chk_main_sticks: assert property (phase_q == PH_MAIN |=> phase_q == PH_MAIN)
      else $error("left the sinc3 path without reset");
   chk_sinc3_full: assert property (!cascade |-> n3_last == f_last[9:0] && lgm == 4'h0)
      else $error("sinc3 ratio differs from the overall ratio");
   chk_sinc3_fixed: assert property (cascade |-> n3_last == 10'h3ff && m_last == 4'(f_last >> 10))
      else $error("cascade ratios do not multiply to the overall ratio");
   chk_hpf_bypass: assert property (ev_out && corner_q == 4'h0 |=> pend_q.chan == $past(raw_all))
      else $error("DC block active with zero corner select");
   chk_chan_off: assert property (ev_out && choff_q == '1 |=> pend_q.chan == $past(raw_all))
      else $error("DC block active on a disabled channel");
   chk_no_gating: assert property (ce && phase_q == PH_MAIN && ev3_q && !cascade |=> pend_v_q)
      else $error("sinc3 result was not passed on");
   chk_settle_time: assert property ($rose(settled) |-> settle_q == 16'(SETTLE_CLK[osr_q]))
      else $error("settled flag at the wrong count");
   chk_resync_clear: assert property (resync |=> cnt3_q == '0 && cntf_q == '0 && !evf_q)
      else $error("resync left decimation state behind");
endmodule
`default_nettype wire

// file: bench/adf_partner.sv
// Far-side model: modulator bit source and stallable sample sink
`default_nettype none
module adf_partner
(
   input wire logic stall,
   output logic [adf_pkg::NCH-1:0] mod_bits,
   output logic smp_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   import adf_pkg::*;
   assign mod_bits = 4'h5;
   // Sink may hold off the stream
   assign smp_ready = !stall;
endmodule
`default_nettype wire

// file: bench/adc_decimation_filter_chain_bench.sv
// Bench for the decimation filter chain: register bus, sample stream, filter paths
`default_nettype none
module adc_decimation_filter_chain_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import adf_pkg::*;
   logic aclk, aresetn, ce, stall;
   logic [NCH-1:0] mod_bits;
   logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready, smp_valid, smp_ready, sample_ready_n;
   logic [AW-1:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, q;
   logic [3:0] s_wstrb;
   logic [1:0] s_bresp, s_rresp, r;
   adf_sample_t smp_data, s;
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int gap, c0;

   adf_chain u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .mod_bits(mod_bits),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr),
      .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
      .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
      .s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr),
      .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata), .s_rresp(s_rresp),
      .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data),
      .sample_ready_n(sample_ready_n));
   adf_partner u_far (.stall(stall), .mod_bits(mod_bits), .smp_ready(smp_ready));

   // 10 MHz master clock and a cycle count for settling checks
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = !aclk;
   end
   always @(posedge aclk) cyc <= cyc + 1;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // One AXI4-Lite access; looks at mid-cycle so the edge value is known before acting
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic ha, hw, hd, mapped;
      hd = 1'b0;
      mapped = a inside {ADDR_CLOCK, ADDR_HPF, ADDR_CHOFF, ADDR_CTRL, ADDR_STATUS};
      s_awaddr <= a;
      s_araddr <= a;
      s_wdata <= d;
      s_awvalid <= w;
      s_wvalid <= w;
      s_arvalid <= !w;
      s_bready <= w;
      s_rready <= !w;
      // No cycle limit here: only the watchdog may end a wait for the answer
      while (!hd)
      begin
         @(negedge aclk);
         ha = s_awvalid && s_awready || s_arvalid && s_arready;
         hw = s_wvalid && s_wready;
         hd = w ? s_bvalid : s_rvalid;
         q = s_rdata;
         r = w ? s_bresp : s_rresp;
         @(posedge aclk);
         if (ha)
         begin
            s_awvalid <= 1'b0;
            s_arvalid <= 1'b0;
         end
         if (hw)
            s_wvalid <= 1'b0;
      end
      // Let an edge pass so the next call never drives the readies twice at once
      s_bready <= 1'b0;
      s_rready <= 1'b0;
      @(posedge aclk);
      check("bus resp", r, mapped ? 32'(RESP_OKAY) : 32'(RESP_DECERR));
   endtask

   // Wait for the next word taken by the sink; gap is cycles since this call began
   task automatic take();
      int t;
      t = 0;
      do
      begin
         @(negedge aclk);
         t++;
      end while (!(smp_valid === 1'b1 && smp_ready) && t < 9000);
      check("ready_n low", sample_ready_n, 1'b0);
      s = smp_data;
      gap = t;
      @(posedge aclk);
   endtask

   task automatic t_reset();
      bus(1'b0, ADDR_CLOCK, 32'h0);
      check("ratio code", q, 32'(OSR_RST));
      bus(1'b0, ADDR_HPF, 32'h0);
      check("corner", q, 32'h0);
      bus(1'b0, ADDR_CHOFF, 32'h0);
      check("chan off", q, 32'h0);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check("status", q, 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      check("unmapped", {q[29:0], r}, 32'h3);
   endtask

   task automatic t_fast();
      take();
      check("first fast", s.fast, 1'b1);
      take();
      check("second fast", s.fast, 1'b1);
      check("fast level", s.chan[0], 32'h400000);
      check("fast gap", gap, 2048);
      take();
      check("third path", s.fast, 1'b0);
      take();
      check("sinc3 high", s.chan[0], 32'h400000);
      check("sinc3 low", s.chan[1], 32'hc00000);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check("path flags", q[5:0], 32'h23);
   endtask

   task automatic t_settle();
      bus(1'b1, ADDR_CLOCK, 32'h0);
      c0 = cyc;
      take();
      check("resync path", s.fast, 1'b0);
      take();
      check("gap 128", gap, 256);
      while (cyc - c0 < 845)
         @(posedge aclk);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check("early settled", q[1], 1'b0);
      repeat (14) @(posedge aclk);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check("late settled", q[1], 1'b1);
      take();
      check("direct sinc3", s.chan[0], 32'h400000);
   endtask

   task automatic t_dc();
      bus(1'b1, ADDR_HPF, 32'h1);
      bus(1'b1, ADDR_CHOFF, 32'h2);
      repeat (40) take();
      check("dc removed", s.chan[0][23:12] == 0 || &s.chan[0][23:12], 1'b1);
      check("chan bypass", s.chan[1], 32'hc00000);
      bus(1'b1, ADDR_HPF, 32'h0);
      repeat (3) take();
      check("hp off", s.chan[0], 32'h400000);
      // A frozen clock enable must push the next sample out by the frozen cycles
      ce <= 1'b0;
      repeat (100) @(posedge aclk);
      ce <= 1'b1;
      take();
      check("frozen gap", gap, 256);
   endtask

   task automatic t_stall();
      stall <= 1'b1;
      repeat (1100) @(posedge aclk);
      check("held valid", {smp_valid, sample_ready_n}, 32'h2);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check("overrun", q[2], 1'b1);
      stall <= 1'b0;
      take();
      take();
      check("buffered pair", gap, 1);
      bus(1'b1, ADDR_STATUS, 32'h4);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check("overrun clear", q[2], 1'b0);
   endtask

   task automatic t_cascade();
      bus(1'b1, ADDR_CLOCK, 32'h4);
      take();
      take();
      check("cascade gap", gap, 4096);
      take();
      check("cascade dc", s.chan[0], 32'h400000);
   endtask

   // Watchdog sized well above the roughly 34k cycles of traffic
   initial
   begin
      #6000000;
      num_errors++;
      complete_run();
   end

   // Main sequence
   initial
   begin
      aresetn = 1'b0;
      ce = 1'b1;
      stall = 1'b0;
      s_awvalid = 1'b0;
      s_wvalid = 1'b0;
      s_arvalid = 1'b0;
      s_bready = 1'b0;
      s_rready = 1'b0;
      s_awaddr = '0;
      s_araddr = '0;
      s_wdata = '0;
      s_wstrb = 4'hf;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_fast();
      t_settle();
      t_dc();
      t_stall();
      t_cascade();
      complete_run();
   end
endmodule
`default_nettype wire
